// File: lbas_defines.svh
// Constants for the local bus arbitration and select block.
`ifndef LBAS_DEFINES_SVH
`define LBAS_DEFINES_SVH
// Clocks after the transfer start during which a select is still accepted.
`define LBAS_SEL_WINDOW 2'h3
// Width of the select window counter.
`define LBAS_SEL_CNT_W 2
// Reset value of the bus master enable bit.
`define LBAS_BME_RESET 1'b0
`endif

// File: lbas_pkg.sv
// Types for the local bus arbitration and select block.
`default_nettype none
package lbas_pkg;
	typedef enum logic [2:0] {LBAS_IDLE, LBAS_REQ, LBAS_WAIT_FREE, LBAS_ASSERT, LBAS_OWN,
		LBAS_RELEASE} lbas_arb_state_t;
	typedef enum logic [1:0] {LBAS_DEC_NONE, LBAS_DEC_PCI, LBAS_DEC_REG} lbas_target_t;
endpackage
`default_nettype wire

// File: lbas_select_sampler.sv
// Chip select sampling window that follows each transfer start.
`timescale 1ns/1ps
`default_nettype none
`include "lbas_defines.svh"
module lbas_select_sampler
	import lbas_pkg::*;
(
	input  wire logic                 sys_clk,             // Local bus clock.
	input  wire logic                 reset_n,             // Asynchronous reset, active low.
	input  wire logic                 clk_en,              // Freezes state while low.
	input  wire logic                 transfer_start_n,    // Transfer start strobe, active low.
	input  wire logic                 pci_window_select_n, // PCI window select, active low.
	input  wire logic                 register_select_n,   // Register select, active low.
	input  wire logic                 independent_dma_cycle,          // Current cycle is independent DMA.
	output logic                      sel_pci,             // Registered PCI hit.
	output logic                      sel_reg,             // Registered register hit.
	output logic                      sel_done,            // One-cycle pulse at window close.
	output logic                      independent_dma_single          // Single-address DMA flag.
);
	logic                          open_q, open_d;
	logic [`LBAS_SEL_CNT_W-1:0]    cnt_q, cnt_d;
	logic                          pci_q, pci_d, reg_q, reg_d, done_q, done_d, single_q, single_d;

	// Opens a window on the start clock and keeps it open for three more clocks.
	always_comb
	begin
		open_d   = open_q;
		cnt_d    = cnt_q;
		pci_d    = pci_q;
		reg_d    = reg_q;
		done_d   = 1'b0;
		single_d = single_q;
		if (!transfer_start_n)
		begin
			open_d   = 1'b1;
			cnt_d    = '0;
			pci_d    = !pci_window_select_n;
			reg_d    = !register_select_n;
			single_d = independent_dma_cycle && !pci_window_select_n;
		end
		else if (open_q)
		begin
			pci_d = pci_q || !pci_window_select_n;
			reg_d = reg_q || !register_select_n;
			if (independent_dma_cycle && !pci_window_select_n)
			begin
				single_d = 1'b1;
			end
			if (cnt_q == `LBAS_SEL_WINDOW - 2'h1)
			begin
				open_d = 1'b0;
				done_d = 1'b1;
			end
			else
			begin
				cnt_d = cnt_q + 2'h1;
			end
		end
	end

	// Registers the window state.
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			open_q   <= 1'b0;
			cnt_q    <= '0;
			pci_q    <= 1'b0;
			reg_q    <= 1'b0;
			done_q   <= 1'b0;
			single_q <= 1'b0;
		end
		else if (clk_en)
		begin
			open_q   <= open_d;
			cnt_q    <= cnt_d;
			pci_q    <= pci_d;
			reg_q    <= reg_d;
			done_q   <= done_d;
			single_q <= single_d;
		end
	end

	assign sel_pci     = pci_q;
	assign sel_reg     = reg_q;
	assign sel_done    = done_q;
	assign independent_dma_single = single_q;
endmodule // lbas_select_sampler
`default_nettype wire

// File: lbas_arbiter.sv
// Local bus arbitration handshake, burst indicator and strap capture.
`timescale 1ns/1ps
`default_nettype none
`include "lbas_defines.svh"
// Summary of operation
// - Request, grant and busy form the handshake.
// - Grant is sampled on the rising edge.
// - Request asserts and releases from rising edges.
// - Asynchronous arbitration mode is selectable.
// - Strap high at reset sets master enable.
// - Initiator asserts burst; target monitors it.
// - PCI select accepted start through three clocks.
// - DMA: select marks single, else dual.
// - Register select sampled start through three clocks.
// - Owner holds busy low, negates before release.
// - Processor mode asserts busy one clock later than standard mode.
module lbas_arbiter
	import lbas_pkg::*;
(
	input  wire logic sys_clk,               // Local bus clock, 20 MHz.
	input  wire logic reset_n,               // Asynchronous reset, active low.
	input  wire logic clk_en,                // Freezes all state while low.
	input  wire logic pci_reset_n,           // PCI reset, active low.
	input  wire logic master_enable_strap,   // Bus master enable strap.
	input  wire logic async_arb_mode,        // Selects asynchronous arbitration.
	input  wire logic proc_arb_mode,         // Busy one clock later than standard mode.
	input  wire logic master_need,           // Bridge wants to master the bus.
	input  wire logic master_burst,          // Bridge transfer is a burst.
	input  wire logic master_done,           // Bridge finished its transfers.
	input  wire logic bus_grant_in_n,        // Grant from arbiter, active low.
	input  wire logic bus_busy_line_in_n,    // Busy line level, active low.
	input  wire logic burst_indicator_in_n,  // Burst line level, active low.
	input  wire logic transfer_start_n,      // Transfer start strobe, active low.
	input  wire logic pci_window_select_n,   // PCI window select, active low.
	input  wire logic register_select_n,     // Register select, active low.
	input  wire logic independent_dma_cycle,            // Current cycle is independent DMA.
	output logic      bus_request_out_n,     // Request to arbiter, active low.
	output logic      bus_busy_line_out_n,   // Busy line drive value, active low.
	output logic      bus_busy_line_oe,      // Busy line output enable.
	output logic      burst_indicator_out_n, // Burst line drive value, active low.
	output logic      burst_indicator_oe,    // Burst line output enable.
	output logic      bus_owned,             // Bridge owns the local bus.
	output logic      target_burst,          // Sampled burst as target.
	output logic      bus_master_enable,     // Master enable bit of PCI command.
	output logic      pci_access,            // Transaction hits the PCI window.
	output logic      reg_access,            // Transaction hits the registers.
	output logic      select_valid,          // One-cycle pulse, selects final.
	output logic      independent_dma_single_addr       // DMA single-address transfer.
);
	lbas_arb_state_t state_q, state_d;
	logic gnt_s1_q, gnt_s2_q, bb_s1_q, bb_s2_q;
	logic req_q, req_d, bb_drv_q, bb_drv_d, bb_oe_q, bb_oe_d, bst_q, bst_d, bst_oe_q, bst_oe_d;
	logic own_q, own_d, tb_q, tb_d, bme_q, bme_d;
	logic pci_q, regs_q, valid_q, single_q;
	logic gnt_seen, busy_seen;
	logic s_pci, s_reg, s_done, s_single;

	// Synchronisers for the asynchronous mode; only the second stage is read.
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			gnt_s1_q <= 1'b1;
			gnt_s2_q <= 1'b1;
			bb_s1_q  <= 1'b1;
			bb_s2_q  <= 1'b1;
		end
		else if (clk_en)
		begin
			gnt_s1_q <= bus_grant_in_n;
			gnt_s2_q <= gnt_s1_q;
			bb_s1_q  <= bus_busy_line_in_n;
			bb_s2_q  <= bb_s1_q;
		end
	end

	// Chooses direct edge sampling or the synchronised copies.
	assign gnt_seen  = async_arb_mode ? !gnt_s2_q : !bus_grant_in_n;
	assign busy_seen = async_arb_mode ? !bb_s2_q : !bus_busy_line_in_n;

	// Arbitration sequence: request, wait for grant with free bus, own, release.
	always_comb
	begin
		state_d  = state_q;
		req_d    = req_q;
		bb_drv_d = bb_drv_q;
		bb_oe_d  = bb_oe_q;
		bst_d    = bst_q;
		bst_oe_d = bst_oe_q;
		own_d    = own_q;
		case (state_q)
			LBAS_IDLE:
			begin
				if (master_need)
				begin
					req_d   = 1'b1;
					state_d = LBAS_REQ;
				end
			end
			LBAS_REQ:
			begin
				if (!master_need)
				begin
					req_d   = 1'b0;
					state_d = LBAS_IDLE;
				end
				else if (gnt_seen && !busy_seen)
				begin
					state_d = proc_arb_mode ? LBAS_WAIT_FREE : LBAS_ASSERT;
				end
			end
			LBAS_WAIT_FREE:
			begin
				state_d = LBAS_ASSERT;
			end
			LBAS_ASSERT:
			begin
				bb_drv_d = 1'b1;
				bb_oe_d  = 1'b1;
				req_d    = 1'b0;
				own_d    = 1'b1;
				state_d  = LBAS_OWN;
			end
			LBAS_OWN:
			begin
				bst_oe_d = 1'b1;
				bst_d    = master_burst;
				if (master_done)
				begin
					bb_drv_d = 1'b0;
					bst_d    = 1'b0;
					state_d  = LBAS_RELEASE;
				end
			end
			LBAS_RELEASE:
			begin
				bb_oe_d  = 1'b0;
				bst_oe_d = 1'b0;
				own_d    = 1'b0;
				state_d  = LBAS_IDLE;
			end
			default:
			begin
				state_d = LBAS_IDLE;
			end
		endcase
	end

	// Burst monitoring as target and strap capture while PCI reset is held.
	always_comb
	begin
		tb_d  = own_q ? 1'b0 : !burst_indicator_in_n;
		bme_d = bme_q;
		if (!pci_reset_n)
		begin
			bme_d = master_enable_strap;
		end
	end

	// Registers the arbitration state.
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_q  <= LBAS_IDLE;
			req_q    <= 1'b0;
			bb_drv_q <= 1'b0;
			bb_oe_q  <= 1'b0;
			bst_q    <= 1'b0;
			bst_oe_q <= 1'b0;
			own_q    <= 1'b0;
			tb_q     <= 1'b0;
			bme_q    <= `LBAS_BME_RESET;
		end
		else if (clk_en)
		begin
			state_q  <= state_d;
			req_q    <= req_d;
			bb_drv_q <= bb_drv_d;
			bb_oe_q  <= bb_oe_d;
			bst_q    <= bst_d;
			bst_oe_q <= bst_oe_d;
			own_q    <= own_d;
			tb_q     <= tb_d;
			bme_q    <= bme_d;
		end
	end

	// Samples the two chip selects after each transfer start.
	lbas_select_sampler u_select
	(
		.sys_clk             (sys_clk),
		.reset_n             (reset_n),
		.clk_en              (clk_en),
		.transfer_start_n    (transfer_start_n),
		.pci_window_select_n (pci_window_select_n),
		.register_select_n   (register_select_n),
		.independent_dma_cycle          (independent_dma_cycle),
		.sel_pci             (s_pci),
		.sel_reg             (s_reg),
		.sel_done            (s_done),
		.independent_dma_single         (s_single)
	);

	// Output flops for the select results, updated one clock after the window closes.
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pci_q    <= 1'b0;
			regs_q   <= 1'b0;
			valid_q  <= 1'b0;
			single_q <= 1'b0;
		end
		else if (clk_en)
		begin
			valid_q <= s_done;
			if (s_done)
			begin
				pci_q    <= s_pci;
				regs_q   <= s_reg;
				single_q <= s_single;
			end
		end
	end

	// Every output is a flop.
	assign bus_request_out_n     = !req_q;
	assign bus_busy_line_out_n   = !bb_drv_q;
	assign bus_busy_line_oe      = bb_oe_q;
	assign burst_indicator_out_n = !bst_q;
	assign burst_indicator_oe    = bst_oe_q;
	assign bus_owned             = own_q;
	assign target_burst          = tb_q;
	assign bus_master_enable     = bme_q;
	assign pci_access            = pci_q;
	assign reg_access            = regs_q;
	assign select_valid          = valid_q;
	assign independent_dma_single_addr      = single_q;
endmodule // lbas_arbiter
`default_nettype wire

// File: lbas_arbiter_assertions.sv
// Concurrent checks on the arbitration and select ports.
`timescale 1ns/1ps
`default_nettype none
module lbas_arbiter_checker
	import lbas_pkg::*;
(
	input wire logic sys_clk,             // Clock.
	input wire logic reset_n,             // Reset.
	input wire logic bus_grant_in_n,      // Grant.
	input wire logic bus_busy_line_in_n,  // Busy level.
	input wire logic transfer_start_n,    // Start.
	input wire logic bus_request_out_n,   // Request.
	input wire logic bus_busy_line_out_n, // Busy drive.
	input wire logic bus_busy_line_oe,    // Busy enable.
	input wire logic burst_indicator_oe,  // Burst enable.
	input wire logic bus_owned,           // Owner.
	input wire logic pci_access,          // PCI hit.
	input wire logic select_valid,        // Selects final.
	input wire logic independent_dma_single_addr     // Single address.
);
	// ------------------------------
	// Properties
	// ------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// Start followed by the three window clocks.
	sequence s_window;
		!transfer_start_n ##1 transfer_start_n [*3];
	endsequence
	a_release_on_own: assert property ($rose(bus_owned) |-> bus_request_out_n)
		else $error("request held after ownership");
	a_busy_after_grant: assert property ($rose(bus_busy_line_oe) |->
		$past(!bus_grant_in_n && bus_busy_line_in_n, 2)) else $error("busy without grant");
	a_busy_owner: assert property (!bus_busy_line_out_n |-> bus_busy_line_oe && bus_owned)
		else $error("busy low while not owner");
	a_negate_first: assert property ($fell(bus_busy_line_oe) |-> $past(bus_busy_line_out_n))
		else $error("busy not negated before release");
	a_burst_owner: assert property (burst_indicator_oe |-> bus_owned)
		else $error("burst driven while not owner");
	a_valid_window: assert property (s_window |-> ##[1:2] select_valid)
		else $error("select result missing");
	a_valid_pulse: assert property (select_valid |=> !select_valid)
		else $error("select valid too long");
	a_pci_latched: assert property ($changed(pci_access) |-> select_valid)
		else $error("pci hit changed outside result");
	a_single_pci: assert property (independent_dma_single_addr |-> pci_access)
		else $error("single address without pci hit");
endmodule // lbas_arbiter_checker
`default_nettype wire

// File: lbas_bus_partner.sv
// Model of the external arbiter, another master and the line pull-ups.
`timescale 1ns/1ps
`default_nettype none
module lbas_bus_partner
	import lbas_pkg::*;
(
	input  wire logic       sys_clk,               // Clock.
	input  wire logic       reset_n,               // Reset.
	input  wire logic [3:0] grant_wait,            // Clocks before grant.
	input  wire logic       other_busy,            // Other master owns.
	input  wire logic       other_burst,           // Other master bursts.
	input  wire logic       bus_request_out_n,     // Request.
	input  wire logic       bus_busy_line_out_n,   // Busy drive.
	input  wire logic       bus_busy_line_oe,      // Busy enable.
	input  wire logic       burst_indicator_out_n, // Burst drive.
	input  wire logic       burst_indicator_oe,    // Burst enable.
	output logic            bus_grant_in_n,        // Grant.
	output logic            bus_busy_line_in_n,    // Busy level.
	output logic            burst_indicator_in_n   // Burst level.
);
	// ------------------------------
	// Arbiter and lines
	// ------------------------------
	logic [3:0] wait_q;
	// Grant follows a pending request after the chosen wait, even if busy.
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wait_q         <= 4'h0;
			bus_grant_in_n <= 1'b1;
		end
		else if (bus_request_out_n)
		begin
			wait_q         <= 4'h0;
			bus_grant_in_n <= 1'b1;
		end
		else if (wait_q < grant_wait)
		begin
			wait_q <= wait_q + 4'h1;
		end
		else
		begin
			bus_grant_in_n <= 1'b0;
		end
	end
	// Pulled-up shared lines, also driven by the other master.
	assign bus_busy_line_in_n = (bus_busy_line_oe ? bus_busy_line_out_n : 1'b1) & !other_busy;
	assign burst_indicator_in_n = (burst_indicator_oe ? burst_indicator_out_n : 1'b1) & !other_burst;
endmodule // lbas_bus_partner
`default_nettype wire

// File: tb_top.sv
// Testbench for the local bus arbitration and select block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// ------------------------------
	// Signals and instances
	// ------------------------------
	logic sys_clk, reset_n, clk_en, pci_reset_n, master_enable_strap, async_arb_mode;
	logic proc_arb_mode, master_need, master_burst, master_done, transfer_start_n;
	logic pci_window_select_n, register_select_n, independent_dma_cycle, other_busy, other_burst;
	logic bus_grant_in_n, bus_busy_line_in_n, burst_indicator_in_n, bus_request_out_n;
	logic bus_busy_line_out_n, bus_busy_line_oe, burst_indicator_out_n, burst_indicator_oe;
	logic bus_owned, target_burst, bus_master_enable, pci_access, reg_access, select_valid;
	logic independent_dma_single_addr;
	logic [3:0] grant_wait;
	int err_count, samples_checked;
	lbas_arbiter lbas_arbiter_inst (.sys_clk, .reset_n, .clk_en, .pci_reset_n,
		.master_enable_strap, .async_arb_mode, .proc_arb_mode, .master_need, .master_burst,
		.master_done, .bus_grant_in_n, .bus_busy_line_in_n, .burst_indicator_in_n,
		.transfer_start_n, .pci_window_select_n, .register_select_n, .independent_dma_cycle,
		.bus_request_out_n, .bus_busy_line_out_n, .bus_busy_line_oe, .burst_indicator_out_n,
		.burst_indicator_oe, .bus_owned, .target_burst, .bus_master_enable, .pci_access,
		.reg_access, .select_valid, .independent_dma_single_addr);
	lbas_bus_partner lbas_bus_partner_inst (.sys_clk, .reset_n, .grant_wait, .other_busy,
		.other_burst, .bus_request_out_n, .bus_busy_line_out_n, .bus_busy_line_oe,
		.burst_indicator_out_n, .burst_indicator_oe, .bus_grant_in_n, .bus_busy_line_in_n,
		.burst_indicator_in_n);
	// Clock of 50 ns period.
	always #25 sys_clk = ~sys_clk;
	task automatic step(input int n = 1);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic bound(input int n);
		if (n >= 40)
		begin
			check(8'h01, 8'h00);
			tally_and_finish();
		end
	endtask
	// Takes the bus, checks the owner drives, then gives it back.
	task automatic own_bus(output int lat);
		lat = 0;
		master_need = 1'b1;
		while (bus_owned !== 1'b1 && lat < 40)
		begin
			step();
			lat++;
		end
		bound(lat);
		step();
		check({bus_request_out_n, bus_busy_line_out_n, bus_busy_line_oe, burst_indicator_oe},
			8'h0b);
		check(burst_indicator_out_n, !master_burst);
		check(target_burst, 1'b0);
		master_done = 1'b1;
		master_need = 1'b0;
		step();
		check({bus_busy_line_out_n, bus_busy_line_oe}, 8'h03);
		master_done = 1'b0;
		step(3);
		check({bus_owned, bus_busy_line_oe, burst_indicator_oe, bus_request_out_n,
			bus_busy_line_out_n, burst_indicator_out_n}, 8'h07);
	endtask
	task automatic t_arbitration;
		int s, p, a;
		master_burst = 1'b1;
		own_bus(s);
		master_burst = 1'b0;
		proc_arb_mode = 1'b1;
		own_bus(p);
		proc_arb_mode = 1'b0;
		async_arb_mode = 1'b1;
		own_bus(a);
		async_arb_mode = 1'b0;
		check(p - s, 1);
		check(a - s, 2);
		$display("test arbitration done");
	endtask
	task automatic t_busy_held;
		int s;
		other_busy = 1'b1;
		grant_wait = 4'h3;
		master_need = 1'b1;
		step(10);
		check({bus_request_out_n, bus_busy_line_oe, bus_owned}, 8'h00);
		master_need = 1'b0;
		step(2);
		check(bus_request_out_n, 1'b1);
		other_busy = 1'b0;
		own_bus(s);
		grant_wait = 4'h0;
		$display("test busy held done");
	endtask
	task automatic t_selects;
		int n;
		for (int k = 0; k < 2; k++)
			for (int d = 0; d < 5; d++)
			begin
				independent_dma_cycle = d[0];
				for (int i = 0; i < 5; i++)
				begin
					transfer_start_n = (i != 0);
					pci_window_select_n = !(k == 0 && i == d);
					register_select_n = !(k == 1 && i == d);
					step();
				end
				pci_window_select_n = 1'b1;
				register_select_n = 1'b1;
				for (n = 0; select_valid !== 1'b1 && n < 40; n++)
					step();
				bound(n);
				check({pci_access, reg_access, independent_dma_single_addr},
					{k == 0 && d < 4, k == 1 && d < 4, k == 0 && d < 4 && d[0]});
				step(2);
			end
		$display("test selects done");
	endtask
	task automatic t_strap_burst;
		pci_reset_n = 1'b0;
		master_enable_strap = 1'b1;
		step(2);
		pci_reset_n = 1'b1;
		master_enable_strap = 1'b0;
		step(2);
		check(bus_master_enable, 1'b1);
		other_burst = 1'b1;
		step(2);
		check(target_burst, 1'b1);
		other_burst = 1'b0;
		step(2);
		check(target_burst, 1'b0);
		clk_en = 1'b0;
		pci_reset_n = 1'b0;
		step(2);
		check(bus_master_enable, 1'b1);
		clk_en = 1'b1;
		step(2);
		check(bus_master_enable, 1'b0);
		pci_reset_n = 1'b1;
		$display("test strap and burst done");
	endtask
	// Main sequence: reset, then each scenario in turn.
	initial
	begin
		{sys_clk, reset_n, master_enable_strap, async_arb_mode, proc_arb_mode} = 5'h00;
		{master_need, master_burst, master_done, independent_dma_cycle, other_busy, other_burst} = 6'h00;
		{clk_en, pci_reset_n, transfer_start_n, pci_window_select_n, register_select_n} = 5'h1f;
		grant_wait = 4'h0;
		step(6);
		check({bus_request_out_n, bus_busy_line_out_n, bus_busy_line_oe, burst_indicator_out_n,
			burst_indicator_oe, bus_owned, bus_master_enable, select_valid}, 8'hd0);
		reset_n = 1'b1;
		t_arbitration();
		t_busy_held();
		t_selects();
		t_strap_burst();
		tally_and_finish();
	end
endmodule // tb_top
bind lbas_arbiter lbas_arbiter_checker lbas_arbiter_checker_inst (.sys_clk, .reset_n,
	.bus_grant_in_n, .bus_busy_line_in_n, .transfer_start_n, .bus_request_out_n,
	.bus_busy_line_out_n, .bus_busy_line_oe, .burst_indicator_oe, .bus_owned, .pci_access,
	.select_valid, .independent_dma_single_addr);
`default_nettype wire
